// ==== ccrs_pkg.sv ====
package ccrs_pkg;

  // ==========================================================
  // pll control word layout (16 bits, output select at bit 12)
  typedef struct packed {
    logic [2:0] rsvd_hi;
    logic       clkout_sel;   // 1: pll clock on shared pin, 0: reset out
    logic [3:0] rsvd_mid;
    logic [1:0] div_code;     // post divider, 2**div_code
    logic [5:0] mult;         // pll multiplier, 0 means bypass
  } ccrs_pll_ctl_t;

  // ==========================================================
  // strap codes and their startup multipliers
  localparam logic [1:0] RATIO_6_STRAP  = 2'h0;
  localparam logic [1:0] RATIO_32_STRAP = 2'h1;
  localparam logic [1:0] RATIO_16_STRAP = 2'h2;
  localparam logic [5:0] MULT_6         = 6'h06;
  localparam logic [5:0] MULT_32        = 6'h20;
  localparam logic [5:0] MULT_16        = 6'h10;
  localparam logic [5:0] MULT_BYPASS    = 6'h00;
  localparam logic [1:0] DIV_RESET      = 2'h0;

  // ==========================================================
  // timing: lock wait counted in input clock cycles
  localparam int          LOCK_CYCLES   = 4096;
  localparam logic [31:0] RESET_VECTOR  = 32'h0000_1000;  // plain default, value arbitrary
  localparam logic [3:0]  IR_CAPTURE    = 4'h1;
  localparam logic        BYP_CAPTURE   = 1'b0;

  // test port state machine
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } ccrs_tap_t;

endpackage

// ============================================================
// lock wait timer: counts input clock cycles after reset release
module ccrs_lock_timer
  import ccrs_pkg::*;
#(
  parameter int CYCLES = LOCK_CYCLES
) (
  input  wire logic                          sys_clk,
  input  wire logic                          srst,
  output logic      [$clog2(CYCLES+1)-1:0]   count,
  output logic                               done
);

  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES);

  logic [W-1:0] cnt_q;

  // saturates so a long run never wraps back into reset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_q <= '0;
    end else if (cnt_q != LAST) begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  assign count = cnt_q;
  assign done  = (cnt_q == LAST);

endmodule

// ==== ccrs_core_clock_reset_sequencer.sv ====
module ccrs_core_clock_reset_sequencer
  import ccrs_pkg::*;
#(
  parameter int          LOCK_WAIT = LOCK_CYCLES,
  parameter logic [31:0] VECTOR    = RESET_VECTOR
) (
  input  wire logic          sys_clk,
  input  wire logic          srst,
  input  wire logic [1:0]    ratio_select_straps,
  input  wire logic          pll_out_level,
  input  wire logic          ctl_wr,
  input  wire ccrs_pll_ctl_t ctl_wdata,
  output ccrs_pll_ctl_t      pll_control_register,
  output logic               core_clk_from_pll,
  output logic               core_rst,
  output logic               exec_start,
  output logic [31:0]        exec_addr,
  output logic               reset_or_clock_output,
  input  wire logic          tck,
  input  wire logic          tms,
  input  wire logic          tdi,
  output logic               tdo,
  output logic               tdo_oe
);

  // ==========================================================
  // strap decoding
  function automatic logic [5:0] strap_mult(input logic [1:0] s);
    case (s)
      RATIO_6_STRAP:  strap_mult = MULT_6;
      RATIO_32_STRAP: strap_mult = MULT_32;
      RATIO_16_STRAP: strap_mult = MULT_16;
      default:        strap_mult = MULT_BYPASS;   // unlisted code runs from input clock
    endcase
  endfunction

  localparam int CW = $clog2(LOCK_WAIT + 1);

  ccrs_pll_ctl_t ctl_q;
  ccrs_pll_ctl_t strap_ctl;
  logic          core_rst_q;
  logic          exec_start_q;
  logic [31:0]   exec_addr_q;
  logic          pin_q;
  logic          lock_done;
  logic [CW-1:0] lock_count;
  logic          ctl_accept;

  // ==========================================================
  // lock wait
  ccrs_lock_timer #(
    .CYCLES (LOCK_WAIT)
  ) u_lock (
    .sys_clk (sys_clk),
    .srst    (srst),
    .count   (lock_count),
    .done    (lock_done)
  );

  // startup control word built from straps
  assign strap_ctl  = '{rsvd_hi: 3'h0, clkout_sel: 1'b0, rsvd_mid: 4'h0,
                        div_code: DIV_RESET, mult: strap_mult(ratio_select_straps)};
  // writes during core reset are dropped, the straps still own the pll then
  assign ctl_accept = ctl_wr && !core_rst_q;

  // control register; straps caught while reset is held
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctl_q <= strap_ctl;
    end else if (ctl_accept) begin
      ctl_q <= '{rsvd_hi: 3'h0, clkout_sel: ctl_wdata.clkout_sel, rsvd_mid: 4'h0,
                 div_code: ctl_wdata.div_code, mult: ctl_wdata.mult};
    end
  end

  // ==========================================================
  // core reset release and start of execution
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      core_rst_q   <= 1'b1;
      exec_start_q <= 1'b0;
      exec_addr_q  <= 32'h0000_0000;
    end else begin
      core_rst_q   <= !lock_done;
      exec_start_q <= core_rst_q && lock_done;
      if (core_rst_q && lock_done) begin
        exec_addr_q <= VECTOR;
      end
    end
  end

  // shared pin: registered so it never glitches between sources
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= ctl_q.clkout_sel ? pll_out_level : core_rst_q;
    end
  end

  assign pll_control_register  = ctl_q;
  assign core_clk_from_pll     = (ctl_q.mult != MULT_BYPASS);
  assign core_rst              = core_rst_q;
  assign exec_start            = exec_start_q;
  assign exec_addr             = exec_addr_q;
  assign reset_or_clock_output = pin_q;

  // ==========================================================
  // test port: tck sampled as a synchronous input
  ccrs_tap_t tap_q;
  ccrs_tap_t tap_d;
  logic      tck_q;
  logic      byp_q;
  logic [3:0] ir_q;
  logic      tdo_q;
  logic      tdo_oe_q;
  wire       tck_rise = tck && !tck_q;
  wire       tck_fall = !tck && tck_q;

  // standard test state walk driven by tms
  always_comb begin
    case (tap_q)
      TAP_RESET:    tap_d = tms ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     tap_d = tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   tap_d = tms ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   tap_d = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_d = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tap_d = tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_d = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tap_d = tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   tap_d = tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   tap_d = tms ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   tap_d = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_d = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tap_d = tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_d = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tap_d = tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   tap_d = tms ? TAP_SEL_DR   : TAP_IDLE;
      default:      tap_d = TAP_RESET;
    endcase
  end

  // state and shift on the rising test clock edge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tck_q <= 1'b0;
      tap_q <= TAP_RESET;
      byp_q <= 1'b0;
      ir_q  <= 4'h0;
    end else begin
      tck_q <= tck;
      if (tck_rise) begin
        tap_q <= tap_d;
        if (tap_q == TAP_CAP_DR)   byp_q <= BYP_CAPTURE;
        if (tap_q == TAP_SHIFT_DR) byp_q <= tdi;
        if (tap_q == TAP_CAP_IR)   ir_q  <= IR_CAPTURE;
        if (tap_q == TAP_SHIFT_IR) ir_q  <= {tdi, ir_q[3:1]};
      end
    end
  end

  // output changes on the falling edge; driven only in shift states
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (tck_fall) begin
      tdo_q    <= (tap_q == TAP_SHIFT_IR) ? ir_q[0] : byp_q;
      tdo_oe_q <= (tap_q == TAP_SHIFT_DR) || (tap_q == TAP_SHIFT_IR);
    end
  end

  assign tdo    = tdo_q;
  assign tdo_oe = tdo_oe_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_lock_end;
    core_rst_q && lock_done;
  endsequence

  // strap 11 is the only startup code that runs the core straight from the input clock
  chk_clock_source: assert property ($fell(srst) |->
      core_clk_from_pll == ($past(ratio_select_straps) != 2'h3))
    else $error("core clock source does not follow straps");
  chk_strap_decode: assert property ($fell(srst) && $past(ratio_select_straps) == 2'h1
                                     |-> ctl_q.mult == 6'h20)
    else $error("strap 01 did not give 32:1");
  chk_write_taken: assert property (ctl_wr && !core_rst_q
                                    |=> ctl_q.mult == $past(ctl_wdata.mult))
    else $error("pll write after reset not taken");
  chk_write_dropped: assert property (ctl_wr && core_rst_q && !$past(srst)
                                      |=> $stable(ctl_q))
    else $error("pll write during core reset changed control");
  chk_pin_reset_mode: assert property (!ctl_q.clkout_sel |=> pin_q == $past(core_rst_q))
    else $error("shared pin does not show core reset");
  chk_pin_clock_mode: assert property (ctl_q.clkout_sel |=> pin_q == $past(pll_out_level))
    else $error("shared pin does not show pll clock");
  chk_hold_reset: assert property (lock_count < CW'(LOCK_WAIT) |=> core_rst_q)
    else $error("core left reset before lock count");
  chk_start_vector: assert property (s_lock_end |=> exec_start_q && exec_addr_q == VECTOR
                                     ##1 !exec_start_q && !core_rst_q)
    else $error("execution start or vector wrong");
  chk_tdo_enable: assert property (tck_fall && tap_q != TAP_SHIFT_DR && tap_q != TAP_SHIFT_IR
                                   |=> !tdo_oe_q)
    else $error("test output driven outside shift");

endmodule

// ==== ccrs_board_model.sv ====
// ==========================================================
// board side: clock source and strap wiring
module ccrs_board_model (
  input  wire logic       sys_clk,
  input  wire logic [1:0] strap_code,
  output logic      [1:0] ratio_select_straps,
  output logic            pll_out_level
);
  timeunit 1ns;
  timeprecision 100ps;

  // straps are plain board wiring, held steady while reset is active
  assign ratio_select_straps = strap_code;

  logic pll_q = 1'b0;

  // pll clock runs free; it moves on the falling edge so that sampling is race free
  always @(negedge sys_clk) begin
    pll_q <= ~pll_q;
  end
  assign pll_out_level = pll_q;
endmodule

// ==== test_ccrs_core_clock_reset_sequencer.sv ====
// ==========================================================
// sequencer bench: straps, lock wait, control writes, shared pin, test port
module test_ccrs_core_clock_reset_sequencer;
  import ccrs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int          LW  = 16;  // short lock wait keeps the run brief
  localparam logic [31:0] VEC = 32'h0000_0200;

  logic          sys_clk, srst, ctl_wr, tck, tms, tdi, pll_lvl;
  logic          core_clk_from_pll, core_rst, exec_start, pin, tdo, tdo_oe, prev;
  logic [1:0]    strap_code, straps;
  logic [3:0]    bits;
  logic [31:0]   exec_addr;
  logic [5:0]    mults [4];
  ccrs_pll_ctl_t ctl_wdata, ctl_q, exp_ctl;
  int            errors, comparisons, cycles;

  ccrs_board_model ccrs_board_model_inst (.sys_clk(sys_clk), .strap_code(strap_code),
    .ratio_select_straps(straps), .pll_out_level(pll_lvl));

  ccrs_core_clock_reset_sequencer #(.LOCK_WAIT(LW), .VECTOR(VEC))
    ccrs_core_clock_reset_sequencer_inst (.sys_clk(sys_clk), .srst(srst),
    .ratio_select_straps(straps), .pll_out_level(pll_lvl), .ctl_wr(ctl_wr),
    .ctl_wdata(ctl_wdata), .pll_control_register(ctl_q),
    .core_clk_from_pll(core_clk_from_pll), .core_rst(core_rst), .exec_start(exec_start),
    .exec_addr(exec_addr), .reset_or_clock_output(pin), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  // ==========================================================
  // clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      conclude();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // one write strobe; the register shows the word after the taking edge
  task automatic write_ctl(logic [15:0] w);
    ctl_wdata = w;
    ctl_wr = 1'b1;
    step();
    ctl_wr = 1'b0;
  endtask

  // tck phases of two system cycles each, never shorter
  task automatic tap(logic tms_v, logic tdi_v);
    tck = 1'b0;
    tms = tms_v;
    tdi = tdi_v;
    repeat (2) step();
    tck = 1'b1;
    repeat (2) step();
  endtask

  // reset with one strap code, then follow the lock wait edge by edge
  task automatic do_reset(logic [1:0] code);
    strap_code = code;
    srst = 1'b1;
    repeat (8) step();
    exp_ctl = '0;
    exp_ctl.mult = mults[code];
    check("ctl in reset", 32'(ctl_q), 32'(exp_ctl));
    check("clk from pll", 32'(core_clk_from_pll), 32'(code != 2'h3));
    check("core_rst in reset", 32'(core_rst), 32'h0000_0001);
    check("pin in reset", 32'(pin), 32'h0000_0001);
    check("tdo_oe in reset", 32'(tdo_oe), 32'h0000_0000);
    srst = 1'b0;
    step();
    write_ctl(16'h1005);  // refused: core still held
    repeat (LW - 2) step();
    check("core_rst at count", 32'(core_rst), 32'h0000_0001);
    check("pin at count", 32'(pin), 32'h0000_0001);
    check("ctl write refused", 32'(ctl_q), 32'(exp_ctl));
    check("start early", 32'(exec_start), 32'h0000_0000);
    step();
    check("core_rst released", 32'(core_rst), 32'h0000_0000);
    check("start pulse", 32'(exec_start), 32'h0000_0001);
    check("start address", exec_addr, VEC);
    step();
    check("start one cycle", 32'(exec_start), 32'h0000_0000);
    check("pin follows reset", 32'(pin), 32'h0000_0000);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    srst = 1'b1;
    ctl_wr = 1'b0;
    ctl_wdata = '0;
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    strap_code = 2'h0;
    errors = 0;
    comparisons = 0;
    cycles = 0;
    mults = '{MULT_6, MULT_32, MULT_16, MULT_BYPASS};
    for (int c = 0; c < 4; c++) do_reset(2'(c));
    // multiplier and divider after start; pin stays on reset
    write_ctl(16'h0094);
    check("ctl write", 32'(ctl_q), 32'h0000_0094);
    check("clk from pll", 32'(core_clk_from_pll), 32'h0000_0001);
    step();
    // reserved bits dropped, pin moves to the pll clock one cycle late
    write_ctl(16'hFFC0);
    check("ctl reserved", 32'(ctl_q), 32'h0000_10C0);
    check("clk direct", 32'(core_clk_from_pll), 32'h0000_0000);
    step();
    for (int i = 0; i < 4; i++) begin
      check("pin clock", 32'(pin), 32'(pll_lvl));
      step();
    end
    do_reset(2'h2);
    // test port: five ones reach reset, then walk into shift-dr
    for (int i = 0; i < 5; i++) tap(1'b1, 1'b0);
    tap(1'b0, 1'b0);
    tap(1'b1, 1'b0);
    tap(1'b0, 1'b0);
    tap(1'b0, 1'b0);
    bits = 4'b1101;
    prev = 1'b0;  // captured bypass value
    for (int i = 0; i < 4; i++) begin
      tap(1'b0, bits[i]);
      check("tdo", 32'(tdo), 32'(prev));
      check("tdo_oe", 32'(tdo_oe), 32'h0000_0001);
      prev = bits[i];
    end
    // back through update-dr into shift-ir; the 4'h1 capture leaves lsb first
    tap(1'b1, 1'b0);
    tap(1'b1, 1'b0);
    check("tdo_oe off shift", 32'(tdo_oe), 32'h0000_0000);
    tap(1'b1, 1'b0);
    tap(1'b1, 1'b0);
    tap(1'b0, 1'b0);
    tap(1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      tap(1'b0, 1'b1);
      check("tdo ir capture", 32'(tdo), 32'(IR_CAPTURE[i]));
    end
    tap(1'b0, 1'b1);
    check("tdo ir shifted", 32'(tdo), 32'h0000_0001);
    conclude();
  end
endmodule
